/* core/t16lp_pkg.sv */
// Package with register map, field layout and constants of the 16-bit low-power timer.
package t16lp_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] T16LP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] T16LP_ADDR_CNT_LOW = 8'h04;
  localparam logic [7:0] T16LP_ADDR_CNT_HIGH = 8'h08;
  localparam logic [7:0] T16LP_ADDR_IRQ = 8'h0c;

  // Field positions inside the control register.
  localparam int T16LP_BIT_WIDE = 7;
  localparam int T16LP_BIT_SYSRUN = 6;
  localparam int T16LP_BIT_PS_HI = 5;
  localparam int T16LP_BIT_PS_LO = 4;
  localparam int T16LP_BIT_OSCEN = 3;
  localparam int T16LP_BIT_NOSYNC = 2;
  localparam int T16LP_BIT_EXTSRC = 1;
  localparam int T16LP_BIT_RUN = 0;

  // Field positions inside the interrupt register.
  localparam int T16LP_BIT_OVF_FLAG = 0;
  localparam int T16LP_BIT_OVF_EN = 1;

  // Values after reset.
  localparam logic [7:0] T16LP_CTRL_RST = 8'h00;
  localparam logic [15:0] T16LP_COUNT_RST = 16'h0000;
  localparam logic [7:0] T16LP_BYTE_RST = 8'h00;

  // Counter limits and the compare mode that requests a special event reset.
  localparam logic [15:0] T16LP_COUNT_MAX = 16'hffff;
  localparam logic [3:0] T16LP_CMP_SPECIAL_MODE = 4'hb;

  // Instruction cycle is the oscillator frequency divided by four.
  localparam int T16LP_INSTR_DIV = 4;
  localparam logic [1:0] T16LP_INSTR_LAST = 2'(T16LP_INSTR_DIV - 1);

  // System clock select code for running from the low-power oscillator.
  localparam logic [1:0] T16LP_SCS_LP_OSC = 2'h1;

  // Power-managed states seen from this block.
  typedef enum logic [1:0] {
    T16LP_PM_OTHER = 2'b00,
    T16LP_PM_SEC_RUN = 2'b01,
    T16LP_PM_SEC_IDLE = 2'b10
  } t16lp_pm_t;

  // Control register fields, bit 7 down to bit 0.
  typedef struct packed {
    logic buffered_wide_access;
    logic sysclk_from_lp_osc;
    logic [1:0] input_prescale_sel;
    logic lp_osc_enable;
    logic ext_sync_disable;
    logic clock_source_sel;
    logic counter_run;
  } t16lp_ctrl_t;

  // One compare unit's special event request.
  typedef struct packed {
    logic trig;
    logic [3:0] mode;
  } t16lp_cmp_t;

endpackage

/* core/t16lp_top.sv */
// 16-bit up-counter with prescaler, low-power oscillator control and APB registers.
`timescale 1ns/100ps
module t16lp_top (
  // Clock and reset.
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // APB slave.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Clock sources from pins.
  input wire logic EXT_CLOCK_PIN_IN,
  input wire logic LP_OSC_CLK_IN,
  // Oscillator control and power-managed mode.
  input wire logic SYSCLK_FROM_LP_OSC_IN,
  input wire logic [1:0] SYSTEM_CLOCK_SELECT_IN,
  input wire logic IDLE_ON_SLEEP_IN,
  input wire logic SLEEP_EXEC_IN,
  input wire logic WAKE_IN,
  output logic LP_OSC_ENABLE_OUT,
  output logic SEC_RUN_OUT,
  output logic SEC_IDLE_OUT,
  // Compare unit special event triggers.
  input wire t16lp_pkg::t16lp_cmp_t CMP_A_IN,
  input wire t16lp_pkg::t16lp_cmp_t CMP_B_IN,
  // Crystal pins as digital port bits, bit 0 crystal input, bit 1 crystal output.
  input wire logic [1:0] PORT_C_DIRECTION_IN,
  input wire logic [1:0] PORT_C_DATA_IN,
  input wire logic [1:0] CRYSTAL_PINS_IN,
  output logic [1:0] CRYSTAL_PINS_O_OUT,
  output logic [1:0] CRYSTAL_PINS_OE_OUT,
  output logic [1:0] PORT_C_READ_OUT,
  // Overflow interrupt.
  output logic OVERFLOW_IRQ_OUT
);

  t16lp_pkg::t16lp_ctrl_t ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] high_buf_reg;
  logic [2:0] pre_cnt_reg;
  logic [1:0] instr_div_reg;
  logic overflow_flag_reg;
  logic overflow_irq_enable_reg;
  logic [31:0] rdata_reg;
  logic sysrun_s1_reg;
  logic sysrun_s2_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic src_prev_reg;
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] port_read_reg;
  t16lp_pkg::t16lp_pm_t pm_reg;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_irq;
  logic rd_low;
  logic instr_tick;
  logic src_level;
  logic src_edge;
  logic raw_tick;
  logic pre_tick;
  logic cnt_tick;
  logic special_rst;
  logic async_mode;
  logic wrap;
  logic cnt_wr;

  // Mask of the prescaler count at which one counter tick is passed on.
  function automatic logic [2:0] pre_mask(input logic [1:0] sel);
    pre_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // True when a compare unit asks for the special event reset.
  function automatic logic cmp_fires(input t16lp_pkg::t16lp_cmp_t c);
    cmp_fires = c.trig && (c.mode == t16lp_pkg::T16LP_CMP_SPECIAL_MODE);
  endfunction

  // APB decode; the slave never waits, so every access phase completes at once.
  assign setup = PSEL_IN && !PENABLE_IN;
  assign acc = PSEL_IN && PENABLE_IN;
  assign wr = acc && PWRITE_IN;
  assign rd = setup && !PWRITE_IN; // Reads are served from the setup phase.
  assign mapped = (PADDR_IN == t16lp_pkg::T16LP_ADDR_CTRL) ||
                  (PADDR_IN == t16lp_pkg::T16LP_ADDR_CNT_LOW) ||
                  (PADDR_IN == t16lp_pkg::T16LP_ADDR_CNT_HIGH) ||
                  (PADDR_IN == t16lp_pkg::T16LP_ADDR_IRQ);
  assign wr_ctrl = wr && (PADDR_IN == t16lp_pkg::T16LP_ADDR_CTRL);
  assign wr_low = wr && (PADDR_IN == t16lp_pkg::T16LP_ADDR_CNT_LOW);
  assign wr_high = wr && (PADDR_IN == t16lp_pkg::T16LP_ADDR_CNT_HIGH);
  assign wr_irq = wr && (PADDR_IN == t16lp_pkg::T16LP_ADDR_IRQ);
  assign rd_low = rd && (PADDR_IN == t16lp_pkg::T16LP_ADDR_CNT_LOW);
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = acc && !mapped;
  assign PRDATA_OUT = rdata_reg;

  // Read data is captured in the setup phase so that it comes from a flip-flop.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd) begin
      case (PADDR_IN)
        t16lp_pkg::T16LP_ADDR_CTRL: rdata_reg <= {24'h00_0000, ctrl_reg};
        t16lp_pkg::T16LP_ADDR_CNT_LOW: rdata_reg <= {24'h00_0000, count_reg[7:0]};
        t16lp_pkg::T16LP_ADDR_CNT_HIGH: begin
          rdata_reg <= {24'h00_0000, ctrl_reg.buffered_wide_access ?
                        high_buf_reg : count_reg[15:8]};
        end
        t16lp_pkg::T16LP_ADDR_IRQ: begin
          rdata_reg <= {30'h0000_0000, overflow_irq_enable_reg, overflow_flag_reg};
        end
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; the status bit is read-only and follows the synchronised input.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      ctrl_reg <= t16lp_pkg::T16LP_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.buffered_wide_access <= PWDATA_IN[t16lp_pkg::T16LP_BIT_WIDE];
        ctrl_reg.input_prescale_sel <=
          PWDATA_IN[t16lp_pkg::T16LP_BIT_PS_HI:t16lp_pkg::T16LP_BIT_PS_LO];
        ctrl_reg.lp_osc_enable <= PWDATA_IN[t16lp_pkg::T16LP_BIT_OSCEN];
        ctrl_reg.ext_sync_disable <= PWDATA_IN[t16lp_pkg::T16LP_BIT_NOSYNC];
        ctrl_reg.clock_source_sel <= PWDATA_IN[t16lp_pkg::T16LP_BIT_EXTSRC];
        ctrl_reg.counter_run <= PWDATA_IN[t16lp_pkg::T16LP_BIT_RUN];
      end
      ctrl_reg.sysclk_from_lp_osc <= sysrun_s2_reg;
    end
  end

  // Two-flop synchronisers for every input that arrives from outside this clock.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      sysrun_s1_reg <= 1'b0;
      sysrun_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
    end else begin
      sysrun_s1_reg <= SYSCLK_FROM_LP_OSC_IN;
      sysrun_s2_reg <= sysrun_s1_reg;
      ext_s1_reg <= EXT_CLOCK_PIN_IN;
      ext_s2_reg <= ext_s1_reg;
      osc_s1_reg <= LP_OSC_CLK_IN;
      osc_s2_reg <= osc_s1_reg;
      pin_s1_reg <= CRYSTAL_PINS_IN;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // The oscillator is gated only by its enable bit, never by the power state.
  assign LP_OSC_ENABLE_OUT = ctrl_reg.lp_osc_enable;

  // Instruction cycle enable: one pulse every fourth system clock.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      instr_div_reg <= 2'h0;
    end else if (instr_div_reg == t16lp_pkg::T16LP_INSTR_LAST) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end
  assign instr_tick = (instr_div_reg == t16lp_pkg::T16LP_INSTR_LAST);

  // External source is the oscillator when enabled, otherwise the clock pin.
  assign src_level = ctrl_reg.lp_osc_enable ? osc_s2_reg : ext_s2_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
    end
  end
  assign src_edge = src_level && !src_prev_reg;
  assign raw_tick = ctrl_reg.clock_source_sel ? src_edge : instr_tick;
  // With one clock the unsynchronised mode still samples the pin; it differs
  // only in that the special event reset is not honoured there.
  assign async_mode = ctrl_reg.clock_source_sel && ctrl_reg.ext_sync_disable;

  // Prescaler; cleared by a low-byte write, left alone by a high-byte write.
  assign pre_tick = raw_tick && (pre_cnt_reg == pre_mask(ctrl_reg.input_prescale_sel));
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      pre_cnt_reg <= 3'h0;
    end else if (wr_low) begin
      pre_cnt_reg <= 3'h0;
    end else if (ctrl_reg.counter_run && raw_tick) begin
      pre_cnt_reg <= pre_tick ? 3'h0 : pre_cnt_reg + 3'h1;
    end
  end

  assign cnt_tick = ctrl_reg.counter_run && pre_tick;
  assign special_rst = (cmp_fires(CMP_A_IN) || cmp_fires(CMP_B_IN)) && !async_mode;
  // In buffered mode a high write only fills the buffer, so it neither swallows a
  // tick nor blocks a special reset.
  assign cnt_wr = wr_low || (wr_high && !ctrl_reg.buffered_wide_access);
  assign wrap = cnt_tick && (count_reg == t16lp_pkg::T16LP_COUNT_MAX) &&
                !cnt_wr && !special_rst;

  // Counter next value: writes first, then special reset, then counting.
  always_comb begin
    count_next = count_reg;
    if (cnt_wr) begin
      if (wr_low) begin
        count_next[7:0] = PWDATA_IN[7:0];
        if (ctrl_reg.buffered_wide_access) begin
          count_next[15:8] = high_buf_reg;
        end
      end
      if (wr_high && !ctrl_reg.buffered_wide_access) begin
        count_next[15:8] = PWDATA_IN[7:0];
      end
    end else if (special_rst) begin
      count_next = t16lp_pkg::T16LP_COUNT_RST;
    end else if (cnt_tick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      count_reg <= t16lp_pkg::T16LP_COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // High-byte buffer: loaded by high writes, and in buffered mode by low-byte reads at the same
  // edge that captures the low byte for read data, so the two halves are always coherent.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      high_buf_reg <= t16lp_pkg::T16LP_BYTE_RST;
    end else if (wr_high) begin
      high_buf_reg <= PWDATA_IN[7:0];
    end else if (rd_low && ctrl_reg.buffered_wide_access) begin
      high_buf_reg <= count_reg[15:8];
    end
  end

  // Overflow flag is sticky; a wrap in the clearing cycle wins over the clear.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      overflow_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_irq && PWDATA_IN[t16lp_pkg::T16LP_BIT_OVF_FLAG]) begin
        overflow_flag_reg <= 1'b0;
      end
      if (wr_irq) begin
        overflow_irq_enable_reg <= PWDATA_IN[t16lp_pkg::T16LP_BIT_OVF_EN];
      end
    end
  end
  assign OVERFLOW_IRQ_OUT = overflow_flag_reg && overflow_irq_enable_reg;

  // Crystal pins lose their digital function while the oscillator is enabled.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      port_read_reg <= 2'h0;
    end else if (ctrl_reg.lp_osc_enable) begin
      port_read_reg <= 2'h0;
    end else begin
      port_read_reg <= pin_s2_reg;
    end
  end
  assign PORT_C_READ_OUT = port_read_reg;
  assign CRYSTAL_PINS_O_OUT = PORT_C_DATA_IN;
  // Direction bit 0 means output, as on a port; ignored under the oscillator.
  assign CRYSTAL_PINS_OE_OUT = ctrl_reg.lp_osc_enable ? 2'h0 : ~PORT_C_DIRECTION_IN;

  // Power-managed view: running from the oscillator, and its idle state on sleep while IDLE_ON_SLEEP_IN is low.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      pm_reg <= t16lp_pkg::T16LP_PM_OTHER;
    end else begin
      case (pm_reg)
        t16lp_pkg::T16LP_PM_OTHER: begin
          if (SYSTEM_CLOCK_SELECT_IN == t16lp_pkg::T16LP_SCS_LP_OSC) begin
            pm_reg <= t16lp_pkg::T16LP_PM_SEC_RUN;
          end
        end
        t16lp_pkg::T16LP_PM_SEC_RUN: begin
          if (SYSTEM_CLOCK_SELECT_IN != t16lp_pkg::T16LP_SCS_LP_OSC) begin
            pm_reg <= t16lp_pkg::T16LP_PM_OTHER;
          end else if (SLEEP_EXEC_IN && !IDLE_ON_SLEEP_IN) begin
            pm_reg <= t16lp_pkg::T16LP_PM_SEC_IDLE;
          end
        end
        t16lp_pkg::T16LP_PM_SEC_IDLE: begin
          if (WAKE_IN) begin
            pm_reg <= t16lp_pkg::T16LP_PM_SEC_RUN;
          end
        end
        default: pm_reg <= t16lp_pkg::T16LP_PM_OTHER;
      endcase
    end
  end
  assign SEC_RUN_OUT = (pm_reg == t16lp_pkg::T16LP_PM_SEC_RUN);
  assign SEC_IDLE_OUT = (pm_reg == t16lp_pkg::T16LP_PM_SEC_IDLE);

  // Checks on the counter, buffer, prescaler and pins.
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);

  AST_PRESCALE_CLEAR: assert property (wr_low |=> pre_cnt_reg == 3'h0)
    else $error("Prescaler not cleared by low-byte write.");
  AST_HIGH_WR_KEEPS_PRE: assert property (wr_high && !raw_tick |=> $stable(pre_cnt_reg))
    else $error("High-byte write disturbed the prescaler.");
  AST_BUF_HIGH_WRITE: assert property (wr_high && ctrl_reg.buffered_wide_access
      |=> high_buf_reg == $past(PWDATA_IN[7:0]) &&
          ($stable(count_reg[15:8]) || count_reg[7:0] == 8'h00))
    else $error("Buffered high write did not load the buffer.");
  AST_LOW_READ_LATCH: assert property (rd_low && ctrl_reg.buffered_wide_access
      && !wr_high |=> high_buf_reg == $past(count_reg[15:8]))
    else $error("Low-byte read did not latch the high byte.");
  AST_WRITE_WINS: assert property (wr_low && special_rst
      |=> count_reg[7:0] == $past(PWDATA_IN[7:0]))
    else $error("Special reset overrode a counter write.");
  AST_SPECIAL_RESET: assert property (special_rst && !wr_low && !wr_high
      |=> count_reg == 16'h0000 && !$rose(overflow_flag_reg))
    else $error("Special event did not reset the counter.");
  AST_OVF_SET: assert property (wrap |=> overflow_flag_reg && count_reg == 16'h0000)
    else $error("Wrap did not set the overflow flag.");
  AST_IRQ_GATE: assert property (wr_irq
      && !PWDATA_IN[t16lp_pkg::T16LP_BIT_OVF_EN] |=> !OVERFLOW_IRQ_OUT)
    else $error("Interrupt output not gated by enable.");
  AST_STOP_HOLD: assert property (!ctrl_reg.counter_run && !wr_low
      && !wr_high && !special_rst |=> $stable(count_reg))
    else $error("Stopped counter changed.");
  AST_PIN_ZERO: assert property (ctrl_reg.lp_osc_enable
      && $past(ctrl_reg.lp_osc_enable)
      |-> PORT_C_READ_OUT == 2'h0 && CRYSTAL_PINS_OE_OUT == 2'h0)
    else $error("Crystal pins active while oscillator enabled.");
  AST_INSTR_RATE: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("Instruction tick not every fourth cycle.");

  COV_WRAP: cover property (wrap ##1 OVERFLOW_IRQ_OUT);
  COV_SPECIAL: cover property (special_rst && count_reg != 16'h0000);
  COV_BUF_READ: cover property (rd_low && ctrl_reg.buffered_wide_access);

endmodule // t16lp_top

/* tb/t16lp_bench.sv */
// Self-checking bench for the 16-bit low-power timer.
`timescale 1ns/100ps
module t16lp_bench;
  `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
  localparam logic [7:0] A_C = t16lp_pkg::T16LP_ADDR_CTRL;
  localparam logic [7:0] A_L = t16lp_pkg::T16LP_ADDR_CNT_LOW;
  localparam logic [7:0] A_H = t16lp_pkg::T16LP_ADDR_CNT_HIGH;
  localparam logic [7:0] A_I = t16lp_pkg::T16LP_ADDR_IRQ;
  localparam logic [3:0] SPEC = t16lp_pkg::T16LP_CMP_SPECIAL_MODE;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arm = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, slv, ext_clk, osc_clk, osc_en, sec_run, sec_idle, irq;
  logic sysclk_osc = 1'b0, sleep = 1'b0, wake = 1'b0, idle_on = 1'b0;
  logic [1:0] system_clock_select = 2'h0, dir = 2'h3, pdata = 2'h0, pins, pins_o, pins_oe, port_rd;
  t16lp_pkg::t16lp_cmp_t cmp_a = '0, cmp_b = '0;
  int err_total = 0, n_checks = 0;

  // Free-running system clock, 4 ns period.
  always #2 clk = ~clk;

  t16lp_top DUT (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXT_CLOCK_PIN_IN(ext_clk),
    .LP_OSC_CLK_IN(osc_clk), .SYSCLK_FROM_LP_OSC_IN(sysclk_osc),
    .SYSTEM_CLOCK_SELECT_IN(system_clock_select), .IDLE_ON_SLEEP_IN(idle_on), .SLEEP_EXEC_IN(sleep),
    .WAKE_IN(wake), .LP_OSC_ENABLE_OUT(osc_en), .SEC_RUN_OUT(sec_run),
    .SEC_IDLE_OUT(sec_idle), .CMP_A_IN(cmp_a), .CMP_B_IN(cmp_b), .PORT_C_DIRECTION_IN(dir),
    .PORT_C_DATA_IN(pdata), .CRYSTAL_PINS_IN(pins), .CRYSTAL_PINS_O_OUT(pins_o),
    .CRYSTAL_PINS_OE_OUT(pins_oe), .PORT_C_READ_OUT(port_rd), .OVERFLOW_IRQ_OUT(irq));

  t16lp_clk_src src (.clk_in(clk), .osc_en_in(osc_en), .ext_clk_out(ext_clk),
    .osc_clk_out(osc_clk), .pins_out(pins));

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer held until pready is seen at an edge; arm adds a coincident trigger.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (arm) begin
      cmp_a <= {1'b1, SPEC};
    end
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        $display("[ERR] %0t no ready", $time);
        give_verdict;
      end
      @(posedge clk);
    end
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp_a <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, {24'h0, e})
  endtask

  // Free-running tick phase makes some counts uncertain by one, so a range is accepted.
  task automatic rdrng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b0, a, 32'h0);
    `CHK(rdv[7:0] >= lo && rdv[7:0] <= hi, 1'b1)
  endtask

  task automatic trig(input logic b, input logic [3:0] m);
    if (b) begin
      cmp_b <= {1'b1, m};
    end else begin
      cmp_a <= {1'b1, m};
    end
    @(posedge clk);
    cmp_a <= '0;
    cmp_b <= '0;
    @(posedge clk);
  endtask

  task automatic t_reset;
    `CHK(irq, 1'b0)
    rdchk(A_C, 8'h00);
    rdchk(A_L, 8'h00);
    rdchk(A_I, 8'h00);
    rdchk(8'h10, 8'h00);
    `CHK(slv, 1'b1)
  endtask

  task automatic t_prescale;
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      e = 8'(64 >> i);
      wr(A_L, 32'h0);
      wr(A_H, 32'h0);
      wr(A_C, 32'(i << 4) | 32'h1);
      wt(256);
      wr(A_C, 32'(i << 4));
      rdrng(A_L, e - 8'h1, e + 8'h1);
      wt(20);
      rdrng(A_L, rdv[7:0], rdv[7:0]);
    end
    wr(A_C, 32'h31);
    repeat (10) begin
      wr(A_L, 32'h0);
      wt(10);
    end
    rdchk(A_L, 8'h00);
    repeat (10) begin
      wr(A_H, 32'h0);
      wt(10);
    end
    wr(A_C, 32'h30);
    rdrng(A_L, 8'h3, 8'h6);
  endtask

  task automatic t_buffer;
    wr(A_C, 32'h80);
    wr(A_L, 32'h0);
    wr(A_H, 32'h12);
    rdchk(A_H, 8'h12);
    rdchk(A_L, 8'h00);
    rdchk(A_H, 8'h00);
    wr(A_H, 32'h12);
    wr(A_L, 32'h34);
    rdchk(A_L, 8'h34);
    rdchk(A_H, 8'h12);
    wr(A_C, 32'h0);
    wr(A_H, 32'h56);
    rdchk(A_H, 8'h56);
    rdchk(A_L, 8'h34);
  endtask

  task automatic t_ovf;
    wr(A_C, 32'h80);
    wr(A_H, 32'hff);
    wr(A_L, 32'hfe);
    wr(A_I, 32'h2);
    wr(A_C, 32'h81);
    wt(20);
    wr(A_C, 32'h80);
    rdrng(A_L, 8'h1, 8'h6);
    rdchk(A_H, 8'h00);
    rdchk(A_I, 8'h03);
    `CHK(irq, 1'b1)
    wr(A_I, 32'h0);
    rdchk(A_I, 8'h01);
    `CHK(irq, 1'b0)
    wr(A_I, 32'h1);
    rdchk(A_I, 8'h00);
  endtask

  // Special resets are used only in the synchronous modes.
  task automatic t_special;
    wr(A_H, 32'h12);
    wr(A_L, 32'h34);
    trig(1'b0, 4'ha);
    rdchk(A_L, 8'h34);
    trig(1'b0, SPEC);
    rdchk(A_L, 8'h00);
    rdchk(A_H, 8'h00);
    wr(A_H, 32'hff);
    wr(A_L, 32'hff);
    trig(1'b1, SPEC);
    rdchk(A_L, 8'h00);
    rdchk(A_I, 8'h00);
    wr(A_H, 32'h66);
    arm = 1'b1;
    wr(A_L, 32'h77);
    arm = 1'b0;
    rdchk(A_L, 8'h77);
    rdchk(A_H, 8'h66);
  endtask

  task automatic t_ext;
    wr(A_C, 32'h02);
    wr(A_L, 32'h0);
    wr(A_H, 32'h0);
    wr(A_C, 32'h03);
    src.pulses(5);
    wt(8);
    rdchk(A_L, 8'h05);
    wr(A_C, 32'h07);
    src.pulses(3);
    wt(8);
    rdchk(A_L, 8'h08);
    wr(A_C, 32'h05);
    wt(40);
    wr(A_C, 32'h04);
    rdrng(A_L, 8'h11, 8'h14);
  endtask

  task automatic t_osc;
    dir <= 2'b01;
    pdata <= 2'b10;
    wt(6);
    `CHK(pins_oe, 2'b10)
    `CHK(pins_o, 2'b10)
    `CHK(port_rd, 2'b01)
    wr(A_C, 32'h0a);
    `CHK(osc_en, 1'b1)
    wt(50);
    `CHK(pins_oe, 2'b00)
    `CHK(port_rd, 2'b00)
    wr(A_L, 32'h0);
    wr(A_C, 32'h0b);
    wt(400);
    wr(A_C, 32'h0a);
    rdrng(A_L, 8'h9, 8'hb);
    system_clock_select <= t16lp_pkg::T16LP_SCS_LP_OSC;
    sysclk_osc <= 1'b1;
    wt(6);
    `CHK(sec_run, 1'b1)
    rdchk(A_C, 8'h4a);
    idle_on <= 1'b1;
    sleep <= 1'b1;
    wt(1);
    sleep <= 1'b0;
    idle_on <= 1'b0;
    wt(3);
    `CHK(sec_idle, 1'b0)
    `CHK(sec_run, 1'b1)
    sleep <= 1'b1;
    wt(1);
    sleep <= 1'b0;
    wt(3);
    `CHK(sec_idle, 1'b1)
    `CHK(osc_en, 1'b1)
    wake <= 1'b1;
    wt(1);
    wake <= 1'b0;
    wt(3);
    `CHK(sec_run, 1'b1)
    system_clock_select <= 2'h0;
    sysclk_osc <= 1'b0;
    wt(6);
    `CHK(sec_run, 1'b0)
    wr(A_C, 32'h40);
    rdchk(A_C, 8'h00);
    `CHK(osc_en, 1'b0)
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: two reset cycles, then every scenario in turn.
  initial begin
    wt(2);
    rst_b <= 1'b1;
    wt(1);
    t_reset;
    t_prescale;
    t_buffer;
    t_ovf;
    t_special;
    t_ext;
    t_osc;
    give_verdict;
  end

  // Watchdog well beyond the few thousand cycles the scenarios need.
  initial begin
    wt(20000);
    err_total++;
    give_verdict;
  end
endmodule // t16lp_bench

/* tb/t16lp_clk_src.sv */
// Model of the external count clock pin, the crystal oscillator and its two pins.
`timescale 1ns/100ps
module t16lp_clk_src (
  // Pacing clock.
  input wire logic clk_in,
  // Oscillator enable from the timer.
  input wire logic osc_en_in,
  // Levels seen by the timer.
  output logic ext_clk_out,
  output logic osc_clk_out,
  output logic [1:0] pins_out
);
  int osc_div = 0;
  // The oscillator runs whenever enabled, in any power state, and stands still when shut off.
  always @(posedge clk_in) begin
    osc_div <= (osc_div == 19) ? 0 : osc_div + 1;
    if (!osc_en_in) begin
      osc_clk_out <= 1'b0;
    end else if (osc_div == 19) begin
      osc_clk_out <= ~osc_clk_out;
    end
  end
  // Running crystal pins swing every period, so a stale digital read would show up.
  assign pins_out = osc_en_in ? {osc_clk_out, ~osc_clk_out} : 2'b01;
  // Pin bursts idle low; each pulse is six clocks high and six low.
  task automatic pulses(input int n);
    repeat (n) begin
      ext_clk_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      ext_clk_out <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask
  initial begin
    ext_clk_out = 1'b0;
  end
endmodule // t16lp_clk_src
